// *** hdl/shp_pkg.sv ***
package shp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // host register indices, selected by the two address pins
  localparam logic [1:0] SHP_REG_CFG_IRQ_WADDR = 2'h0;
  localparam logic [1:0] SHP_REG_DATA_LOW = 2'h1;
  localparam logic [1:0] SHP_REG_DATA_MID = 2'h2;
  localparam logic [1:0] SHP_REG_DATA_HIGH = 2'h3;

  // fields of a write to the high data and page register
  localparam int SHP_HIGH_PAGE_BIT = 7;
  localparam int SHP_HIGH_MODE_BIT = 6;
  localparam int SHP_HIGH_DATA_W = 3;

  // configuration byte after reset: idle, no offset, masked, 18 slots
  localparam logic [7:0] SHP_CFG_RESET = 8'h00;

  // slot count decode
  localparam logic [5:0] SHP_SLOTS_SHORT = 6'h10;
  localparam logic [5:0] SHP_SLOTS_BASE = 6'h12;

  // parameter memory shape
  localparam int SHP_WORD_W = 19;
  localparam int SHP_PRAM_ADDR_W = 9;
  localparam int SHP_PRAM_DEPTH = 512;
  localparam logic [3:0] SHP_COMMON_WORD_INDEX = 4'hf;
  localparam int SHP_COMMON_BUSY_BIT = 18;

  // host settle time after a memory request, in clock cycles
  localparam logic [6:0] SHP_HOST_SETTLE_CYCLES = 7'h44;

  ////////////////////////////////////////////////////////////////////////////
  // configuration byte, msb first as written by the host
  typedef struct packed {
    logic runEnable;
    logic outputDcOffsetEnable;
    logic envelopeIrqEnable;
    logic serialFormatSelect;
    logic [3:0] slotCountSelect;
  } shp_cfg_s;

  // one sampled copy of the host bus pins
  typedef struct packed {
    logic csN;
    logic wrN;
    logic rdN;
    logic [1:0] addr;
    logic [7:0] data;
  } shp_host_pins_s;

  // whole state of the host port
  typedef struct packed {
    shp_host_pins_s sync1;
    shp_host_pins_s sync2;
    shp_host_pins_s prev;
    shp_cfg_s cfg;
    logic [5:0] slotCount;
    logic cfgMode;
    logic page;
    logic [7:0] wordAddr;
    logic [7:0] lowHold;
    logic [7:0] midHold;
    logic [18:0] readWord;
    logic readPending;
    logic [7:0] irqCode;
    logic irqPending;
    logic irqN;
    logic [6:0] busyCount;
    logic busy;
    logic [7:0] dataOut;
    logic dataOe;
    logic ramWrEn;
    logic ramRdEn;
    logic [8:0] ramAddr;
    logic [18:0] ramWrData;
    logic coreIdx15;
    logic [18:0] coreRdData;
  } shp_port_state_s;

endpackage

// *** hdl/shp_param_ram.sv ***
`timescale 1ns/1ps

// parameter memory in flip-flops, one port for the host, one for the core
module shp_param_ram #(
  parameter int DEPTH = 512,
  parameter int WIDTH = 19,
  parameter int ADDR_W = 9
) (
  input wire logic clk, // system clock
  input wire logic hostWrEn, // host write strobe
  input wire logic hostRdEn, // host read strobe
  input wire logic [ADDR_W-1:0] hostAddr, // host word address
  input wire logic [WIDTH-1:0] hostWrData, // host write word
  output logic [WIDTH-1:0] hostRdData, // host read word, registered
  input wire logic coreWrEn, // synthesis core write strobe
  input wire logic [ADDR_W-1:0] coreAddr, // synthesis core word address
  input wire logic [WIDTH-1:0] coreWrData, // synthesis core write word
  output logic [WIDTH-1:0] coreRdData // synthesis core word, registered
);

  logic [DEPTH-1:0][WIDTH-1:0] mem_r;
  logic [DEPTH-1:0][WIDTH-1:0] mem_nxt;
  logic [WIDTH-1:0] hostRd_r;
  logic [WIDTH-1:0] hostRd_nxt;
  logic [WIDTH-1:0] coreRd_r;
  logic [WIDTH-1:0] coreRd_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // core write goes last so working storage wins a same-word collision
  always_comb
  begin
    mem_nxt = mem_r;
    hostRd_nxt = hostRdEn ? mem_r[hostAddr] : hostRd_r;
    coreRd_nxt = mem_r[coreAddr];
    if (hostWrEn)
    begin
      mem_nxt[hostAddr] = hostWrData;
    end
    if (coreWrEn)
    begin
      mem_nxt[coreAddr] = coreWrData;
    end
  end

  // no reset: contents are undefined until written, as in a real array
  always_ff @(posedge clk)
  begin
    mem_r <= mem_nxt;
    hostRd_r <= hostRd_nxt;
    coreRd_r <= coreRd_nxt;
  end

  assign hostRdData = hostRd_r;
  assign coreRdData = coreRd_r;

endmodule

// *** hdl/shp_host_port.sv ***
`timescale 1ns/1ps

// What this block does
// RULE_01 - slot count field: 16, or 18+2n slots
// RULE_02 - address 3 with bit6 enters config mode
// RULE_03 - read-only register names interrupting slot, generator
// RULE_04 - read at address 0 returns interrupt register
// RULE_05 - sixteen 19-bit words per slot, also workspace
// RULE_06 - page bit plus slot nibble plus index nibble
// RULE_07 - page 0 slots 0-15, page 1 upper slots
// RULE_08 - word 15 carries algorithm, mix, phase, busy
// RULE_09 - addresses 0,1,2 take word address, low, mid
// RULE_10 - address 3 bit6 low latches page, writes
// RULE_11 - host waits 68 cycles after write request
// RULE_12 - low and mid holding bytes persist
// RULE_13 - address, low, mid writes in any order
// RULE_14 - latched page also applies to reads
// RULE_15 - page select for read needs dummy read
// RULE_16 - host may skip page select if loaded
// RULE_17 - word address write starts read, 68 cycles
// RULE_18 - addresses 1,2,3 return read word slices
// RULE_19 - config mode ends after the next access
// RULE_20 - two address pins, eight data, three strobes
// RULE_21 - write-only config bits, all zero at reset
// RULE_22 - envelope endpoint raises host interrupt
module shp_host_port (
  input wire logic clk, // 250 MHz system clock
  input wire logic reset, // synchronous reset, active high
  input wire logic hostCsN, // chip select pin, active low
  input wire logic hostWrN, // write strobe pin, active low
  input wire logic hostRdN, // read strobe pin, active low
  input wire logic hostAddrBit0, // address pin 0
  input wire logic hostAddrBit1, // address pin 1
  input wire logic [7:0] hostDataBusIn, // data pins, level seen
  output logic [7:0] hostDataBusOut, // data pins, driven value
  output logic hostDataBusOe, // data pins driven when high
  output logic hostIrqN, // envelope interrupt, active low
  input wire logic envEventValid, // envelope endpoint reached, pulse
  input wire logic [7:0] envEventCode, // slot and generator of event
  input wire logic coreWrEn, // core writes parameter word
  input wire logic [8:0] coreAddr, // core parameter address
  input wire logic [18:0] coreWrData, // core write word
  output logic [18:0] coreRdData, // core read word, two cycles late
  output shp_pkg::shp_cfg_s cfgOut, // configuration bits
  output logic [5:0] activeSlotCount, // decoded slot count
  output logic hostOpBusy // memory request settle window
);
  import shp_pkg::*;

  shp_port_state_s q_r;
  shp_port_state_s s_nxt;
  logic [18:0] ramHostRd;
  logic [18:0] ramCoreRd;
  logic wrDone;
  logic rdDone;

  ////////////////////////////////////////////////////////////////////////////
  // slot count from the four select bits
  function automatic logic [5:0] slotsFromSelect(input logic [3:0] sel);
    logic [5:0] extra;
    extra = {2'h0, sel[2:0], 1'b0};
    if (sel[3])
    begin
      slotsFromSelect = SHP_SLOTS_SHORT; // [RULE_01]
    end
    else
    begin
      slotsFromSelect = SHP_SLOTS_BASE + extra; // [RULE_01]
    end
  endfunction

  // memory address: page, then slot nibble, then index nibble
  function automatic logic [8:0] pramAddr(input logic pg,
                                          input logic [7:0] inPage);
    pramAddr = {pg, inPage}; // [RULE_06] [RULE_07]
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // strobe ends, seen on the synchronised copies; the strobe's own
  // address and data are taken from the sample before the edge
  assign wrDone = !q_r.prev.csN && !q_r.prev.wrN && q_r.sync2.wrN; // [RULE_20]
  assign rdDone = !q_r.prev.csN && !q_r.prev.rdN && q_r.sync2.rdN;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    s_nxt = q_r;
    // pins pass two flops before any logic looks at them
    s_nxt.sync1 = {hostCsN, hostWrN, hostRdN, hostAddrBit1, hostAddrBit0,
                   hostDataBusIn};
    s_nxt.sync2 = q_r.sync1;
    s_nxt.prev = q_r.sync2;
    s_nxt.ramWrEn = 1'b0;
    s_nxt.ramRdEn = 1'b0;

    // settle counter only informs; the host is trusted to keep the gap
    if (q_r.busyCount != 7'h00)
    begin
      s_nxt.busyCount = q_r.busyCount - 7'h01; // [RULE_11]
    end

    // any completed access ends configuration mode
    if ((wrDone || rdDone) && q_r.cfgMode)
    begin
      s_nxt.cfgMode = 1'b0; // [RULE_19] [RULE_15]
    end

    if (wrDone)
    begin
      case (q_r.prev.addr)
        SHP_REG_CFG_IRQ_WADDR:
        begin
          if (q_r.cfgMode)
          begin
            s_nxt.cfg = shp_cfg_s'(q_r.prev.data); // [RULE_02] [RULE_21]
            s_nxt.slotCount = slotsFromSelect(q_r.prev.data[3:0]); // [RULE_01]
          end
          else
          begin
            // word address write doubles as the read request
            s_nxt.wordAddr = q_r.prev.data; // [RULE_09] [RULE_13]
            s_nxt.ramRdEn = 1'b1; // [RULE_17]
            s_nxt.ramAddr = pramAddr(q_r.page, q_r.prev.data); // [RULE_14]
            s_nxt.busyCount = SHP_HOST_SETTLE_CYCLES; // [RULE_17]
          end
        end
        SHP_REG_DATA_LOW:
        begin
          s_nxt.lowHold = q_r.prev.data; // [RULE_09] [RULE_12]
        end
        SHP_REG_DATA_MID:
        begin
          s_nxt.midHold = q_r.prev.data; // [RULE_09] [RULE_12]
        end
        SHP_REG_DATA_HIGH:
        begin
          s_nxt.page = q_r.prev.data[SHP_HIGH_PAGE_BIT]; // [RULE_10] [RULE_15]
          if (q_r.prev.data[SHP_HIGH_MODE_BIT])
          begin
            s_nxt.cfgMode = 1'b1; // [RULE_02] [RULE_15]
          end
          else
          begin
            s_nxt.ramWrEn = 1'b1; // [RULE_10]
            s_nxt.ramAddr = pramAddr(q_r.prev.data[SHP_HIGH_PAGE_BIT],
                                     q_r.wordAddr); // [RULE_10] [RULE_13]
            s_nxt.ramWrData = {q_r.prev.data[SHP_HIGH_DATA_W-1:0],
                               q_r.midHold, q_r.lowHold}; // [RULE_05]
            s_nxt.busyCount = SHP_HOST_SETTLE_CYCLES; // [RULE_11]
          end
        end
        default:
        begin
          s_nxt.cfgMode = q_r.cfgMode;
        end
      endcase
    end
    s_nxt.busy = (s_nxt.busyCount != 7'h00);

    // read word lands two cycles after the request leaves this block
    s_nxt.readPending = q_r.ramRdEn;
    if (q_r.readPending)
    begin
      s_nxt.readWord = ramHostRd; // [RULE_17]
    end

    // interrupt source: reading it clears, a new event in the same cycle
    // wins; events while one is pending are dropped to keep the first
    if (rdDone && q_r.prev.addr == SHP_REG_CFG_IRQ_WADDR)
    begin
      s_nxt.irqPending = 1'b0;
    end
    if (envEventValid && (!q_r.irqPending || !s_nxt.irqPending))
    begin
      s_nxt.irqPending = 1'b1; // [RULE_22]
      s_nxt.irqCode = envEventCode; // [RULE_03]
    end
    s_nxt.irqN = !(s_nxt.irqPending && s_nxt.cfg.envelopeIrqEnable); // [RULE_22]

    // read data mux, driven while chip select and read are both low and write is high
    s_nxt.dataOe = !q_r.sync2.csN && !q_r.sync2.rdN && q_r.sync2.wrN;
    case (q_r.sync2.addr)
      SHP_REG_CFG_IRQ_WADDR:
      begin
        s_nxt.dataOut = q_r.irqCode; // [RULE_04]
      end
      SHP_REG_DATA_LOW:
      begin
        s_nxt.dataOut = q_r.readWord[7:0]; // [RULE_18]
      end
      SHP_REG_DATA_MID:
      begin
        s_nxt.dataOut = q_r.readWord[15:8]; // [RULE_18]
      end
      SHP_REG_DATA_HIGH:
      begin
        s_nxt.dataOut = {5'h00, q_r.readWord[18:16]}; // [RULE_18]
      end
      default:
      begin
        s_nxt.dataOut = 8'h00;
      end
    endcase

    // core view of the common word: busy reads clear while run is off,
    // so every slot looks idle whatever the memory holds
    s_nxt.coreIdx15 = (coreAddr[3:0] == SHP_COMMON_WORD_INDEX);
    s_nxt.coreRdData = ramCoreRd;
    if (q_r.coreIdx15 && !q_r.cfg.runEnable)
    begin
      s_nxt.coreRdData[SHP_COMMON_BUSY_BIT] = 1'b0; // [RULE_08] [RULE_21]
    end

    // pins idle high under reset so no strobe edge is invented
    if (reset)
    begin
      s_nxt = '0;
      s_nxt.sync1 = {3'h7, 10'h000};
      s_nxt.sync2 = {3'h7, 10'h000};
      s_nxt.prev = {3'h7, 10'h000};
      s_nxt.cfg = shp_cfg_s'(SHP_CFG_RESET); // [RULE_21]
      s_nxt.slotCount = SHP_SLOTS_BASE; // [RULE_01]
      s_nxt.irqN = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk)
  begin
    q_r <= s_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // parameter memory, 32 slots by 16 words
  shp_param_ram #(
    .DEPTH(SHP_PRAM_DEPTH),
    .WIDTH(SHP_WORD_W),
    .ADDR_W(SHP_PRAM_ADDR_W)
  ) u_pram (
    .clk(clk),
    .hostWrEn(q_r.ramWrEn), // [RULE_05]
    .hostRdEn(q_r.ramRdEn),
    .hostAddr(q_r.ramAddr),
    .hostWrData(q_r.ramWrData),
    .hostRdData(ramHostRd),
    .coreWrEn(coreWrEn),
    .coreAddr(coreAddr),
    .coreWrData(coreWrData),
    .coreRdData(ramCoreRd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register
  assign hostDataBusOut = q_r.dataOut;
  assign hostDataBusOe = q_r.dataOe;
  assign hostIrqN = q_r.irqN;
  assign coreRdData = q_r.coreRdData;
  assign cfgOut = q_r.cfg;
  assign activeSlotCount = q_r.slotCount;
  assign hostOpBusy = q_r.busy;

endmodule

// *** tb/shp_checker.sv ***
`timescale 1ns/1ps

// pin-level watch on the host port
module shp_checker
  import shp_pkg::*;
(
  input wire logic clk, // clock
  input wire logic reset, // sync reset
  input wire logic hostCsN, // select
  input wire logic hostWrN, // write strobe
  input wire logic hostRdN, // read strobe
  input wire logic hostAddrBit0, // address 0
  input wire logic hostAddrBit1, // address 1
  input wire logic [7:0] hostDataBusIn, // data level
  input wire logic hostDataBusOe, // drive enable
  input wire logic hostIrqN, // interrupt
  input wire logic envEventValid, // event pulse
  input wire logic coreWrEn, // core write
  input wire logic [8:0] coreAddr, // core address
  input wire logic [18:0] coreWrData, // core data
  input wire logic [18:0] coreRdData, // core word
  input wire shp_pkg::shp_cfg_s cfgOut, // config
  input wire logic [5:0] activeSlotCount, // slots
  input wire logic hostOpBusy // settle window
);
  import shp_pkg::*;
  logic [7:0] busyCnt_r;

  ////////////////////////////////////////////////////////////////////////////
  // length of the busy run, so its exact span is checkable
  always_ff @(posedge clk)
  begin
    if (reset || !hostOpBusy)
      busyCnt_r <= 8'h00;
    else
      busyCnt_r <= busyCnt_r + 8'h01;
  end

  function automatic logic [5:0] slots(logic [3:0] s);
    return s[3] ? SHP_SLOTS_SHORT : SHP_SLOTS_BASE + {2'h0, s[2:0], 1'b0};
  endfunction

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////
  sequence s_rdLow;
    (!hostCsN && !hostRdN) [*4];
  endsequence
  sequence s_reqWr;
    $rose(hostWrN) && !hostCsN && hostAddrBit1 && hostAddrBit0 &&
      !hostDataBusIn[SHP_HIGH_MODE_BIT];
  endsequence
  sequence s_coreWr;
    coreWrEn && coreAddr[3:0] != SHP_COMMON_WORD_INDEX ##1
      !coreWrEn && $stable(coreAddr);
  endsequence

  property p_rst;
    disable iff (1'b0) reset |=> cfgOut == SHP_CFG_RESET &&
      activeSlotCount == SHP_SLOTS_BASE && !hostOpBusy && hostIrqN &&
      !hostDataBusOe;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_slot;
    $stable(cfgOut) [*3] |-> activeSlotCount == slots(cfgOut.slotCountSelect);
  endproperty
  a_slot: assert property (p_slot) else $error("slot decode");
  property p_oeOn;
    s_rdLow |-> hostDataBusOe;
  endproperty
  a_oeOn: assert property (p_oeOn) else $error("read not driven");
  property p_oeOff;
    (hostCsN || hostRdN) [*4] |-> !hostDataBusOe;
  endproperty
  a_oeOff: assert property (p_oeOff) else $error("bus not freed");
  property p_busyGo;
    s_reqWr |-> ##[1:5] hostOpBusy;
  endproperty
  a_busyGo: assert property (p_busyGo) else $error("no write start");
  property p_busyLen;
    $fell(hostOpBusy) && !$past(reset) |-> busyCnt_r == 8'h44;
  endproperty
  a_busyLen: assert property (p_busyLen) else $error("busy span");
  property p_irq;
    envEventValid && cfgOut.envelopeIrqEnable |=> !hostIrqN;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not raised");
  property p_core;
    s_coreWr |-> ##2 coreRdData == $past(coreWrData, 3);
  endproperty
  a_core: assert property (p_core) else $error("core word lost");
endmodule

bind shp_host_port shp_checker chk (.clk(clk), .reset(reset),
  .hostCsN(hostCsN), .hostWrN(hostWrN), .hostRdN(hostRdN),
  .hostAddrBit0(hostAddrBit0), .hostAddrBit1(hostAddrBit1),
  .hostDataBusIn(hostDataBusIn), .hostDataBusOe(hostDataBusOe),
  .hostIrqN(hostIrqN), .envEventValid(envEventValid),
  .coreWrEn(coreWrEn), .coreAddr(coreAddr), .coreWrData(coreWrData),
  .coreRdData(coreRdData), .cfgOut(cfgOut),
  .activeSlotCount(activeSlotCount), .hostOpBusy(hostOpBusy));

// *** tb/shp_host_model.sv ***
`timescale 1ns/1ps

// microprocessor on the eight-bit strobe bus
module shp_host_model (
  input wire logic clk, // clock
  input wire logic [7:0] busIn, // data wire level
  output logic csN, // select
  output logic wrN, // write strobe
  output logic rdN, // read strobe
  output logic [1:0] addr, // register select
  output logic [7:0] busOut // data when host drives
);
  initial
  begin
    csN = 1'b1;
    wrN = 1'b1;
    rdN = 1'b1;
    addr = 2'h0;
    busOut = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // strobes held 5 clk so the 2-flop sync sees steady pins
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(negedge clk);
    csN = 1'b0;
    addr = a;
    busOut = d;
    wrN = 1'b0;
    repeat (5) @(negedge clk);
    wrN = 1'b1;
    @(negedge clk);
    csN = 1'b1;
    busOut = ~d; // released lines do not keep the value
    repeat (5) @(negedge clk);
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(negedge clk);
    csN = 1'b0;
    addr = a;
    rdN = 1'b0;
    repeat (5) @(negedge clk);
    d = busIn;
    rdN = 1'b1;
    @(negedge clk);
    csN = 1'b1;
    repeat (5) @(negedge clk);
  endtask
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps

module testbench;
  import shp_pkg::*;
  logic clk, reset, envValid, coreWrEn, dOe, irqN, busy;
  logic csN, wrN, rdN;
  logic [1:0] addr;
  logic [7:0] envCode, busWire, hBus, dOut, rdv;
  logic [8:0] coreAddr;
  logic [18:0] coreWrData, coreRdData;
  logic [5:0] slots;
  shp_cfg_s cfg;
  int miscompares, nCompared;

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  assign busWire = dOe ? dOut : hBus;

  shp_host_port dut (.clk(clk), .reset(reset), .hostCsN(csN),
    .hostWrN(wrN), .hostRdN(rdN), .hostAddrBit0(addr[0]),
    .hostAddrBit1(addr[1]), .hostDataBusIn(busWire),
    .hostDataBusOut(dOut), .hostDataBusOe(dOe), .hostIrqN(irqN),
    .envEventValid(envValid), .envEventCode(envCode),
    .coreWrEn(coreWrEn), .coreAddr(coreAddr), .coreWrData(coreWrData),
    .coreRdData(coreRdData), .cfgOut(cfg), .activeSlotCount(slots),
    .hostOpBusy(busy));
  shp_host_model hm (.clk(clk), .busIn(busWire), .csN(csN), .wrN(wrN),
    .rdN(rdN), .addr(addr), .busOut(hBus));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    if (miscompares == 0 && nCompared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cfgw(input logic [7:0] c);
    hm.wr(2'h3, 8'h40);
    hm.wr(2'h0, c);
  endtask

  // low byte before the address on purpose; bytes skipped when reused
  task automatic pwr(logic p, logic [7:0] wa, logic [18:0] w, bit b);
    if (b)
      hm.wr(2'h1, w[7:0]);
    hm.wr(2'h0, wa);
    // the address write also requests a read, so keep its settle gap
    repeat (70) @(negedge clk);
    if (b)
      hm.wr(2'h2, w[15:8]);
    hm.wr(2'h3, {p, 4'h0, w[18:16]});
    repeat (70) @(negedge clk);
  endtask

  // page select with dummy read, request, bytes in reverse order
  task automatic prd(logic p, logic [7:0] wa, logic [18:0] w);
    hm.wr(2'h3, {p, 7'h40});
    hm.rd(2'h1, rdv);
    hm.wr(2'h0, wa);
    repeat (70) @(negedge clk);
    hm.rd(2'h3, rdv);
    check(rdv[2:0], w[18:16]);
    hm.rd(2'h2, rdv);
    check(rdv, w[15:8]);
    hm.rd(2'h1, rdv);
    check(rdv, w[7:0]);
    coreAddr = {p, wa};
    repeat (3) @(negedge clk);
    check(coreRdData, w);
  endtask

  task automatic ev(input logic [7:0] c);
    @(negedge clk);
    envValid = 1'b1;
    envCode = c;
    @(negedge clk);
    envValid = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    reset = 1'b1;
    {envValid, coreWrEn, envCode, coreAddr, coreWrData} = '0;
    miscompares = 0;
    nCompared = 0;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    check(cfg, SHP_CFG_RESET);
    for (int s = 0; s < 16; s++)
    begin
      cfgw({4'h0, s[3:0]});
      check(cfg, {4'h0, s[3:0]});
      check(slots, s[3] ? 6'h10 : 6'h12 + {2'h0, s[2:0], 1'b0});
    end
    cfgw(8'h20);
    pwr(1'b0, 8'h25, 19'h5a3c1, 1'b1);
    pwr(1'b1, 8'h3e, 19'h2a3c1, 1'b0);
    check(cfg, 8'h20);
    // page one still latched from the write, no page select
    hm.wr(2'h0, 8'h3e);
    repeat (70) @(negedge clk);
    hm.rd(2'h3, rdv);
    check(rdv[2:0], 3'h2);
    prd(1'b0, 8'h25, 19'h5a3c1);
    prd(1'b1, 8'h3e, 19'h2a3c1);
    // core writes the last slot, host reads it back
    @(negedge clk);
    coreAddr = 9'h1f3;
    coreWrData = 19'h6d5b7;
    coreWrEn = 1'b1;
    @(negedge clk);
    coreWrEn = 1'b0;
    prd(1'b1, 8'hf3, 19'h6d5b7);
    // run is off, so the busy bit of word 15 reads idle
    pwr(1'b0, 8'h0f, 19'h7ffff, 1'b1);
    coreAddr = 9'h00f;
    repeat (3) @(negedge clk);
    check(coreRdData, 19'h3ffff);
    ev(8'h5a);
    check(irqN, 1'b0);
    ev(8'h33);
    hm.rd(2'h0, rdv);
    check(rdv, 8'h5a);
    check(irqN, 1'b1);
    cfgw(8'h00);
    ev(8'h11);
    check(irqN, 1'b1);
    end_sim();
  end

  // whole run is near 6 us; over six times that means a hang
  initial
  begin
    #40000;
    miscompares++;
    end_sim();
  end
endmodule
